//--- design/output_current_fault_response.sv
`timescale 1ns/1ps
module output_current_fault_response #(
  parameter int NOUT         = fault_resp_pkg::NUM_OUTPUTS,
  parameter int RETRY_CYCLES = fault_resp_pkg::RETRY_CYCLES
) (
  input  wire logic            MCLK,
  input  wire logic            RST_N,
  input  wire logic [7:0]      CMD_CODE,
  input  wire logic [0:0]      PAGE,
  input  wire logic            WR_STB,
  input  wire logic [7:0]      WR_DATA,
  input  wire logic            WRITE_PROTECT,
  input  wire logic            CLEAR_FAULTS,
  input  wire logic [NOUT-1:0] OC_FAULT,
  input  wire logic [NOUT-1:0] UC_FAULT,
  input  wire logic [NOUT-1:0] CMD_ON,
  input  wire logic [NOUT-1:0] OTHER_FAULT,
  output logic [7:0]           RD_DATA,
  output logic [NOUT-1:0]      OUTPUT_ENABLE,
  output logic [NOUT-1:0]      RESTART_STB,
  output logic [1:0]           OUTPUT_CURRENT_STATUS [NOUT],
  output logic                 ALERT_LINE_N
);
  typedef enum logic [1:0] {ST_RUN, ST_OFF, ST_WAIT} out_state_t;

  logic [7:0]  oc_cfg_ff   [NOUT];
  logic [7:0]  nxt_oc_cfg  [NOUT];
  logic [7:0]  uc_cfg_ff   [NOUT];
  logic [7:0]  nxt_uc_cfg  [NOUT];
  logic [1:0]  stat_ff     [NOUT];
  logic [1:0]  nxt_stat    [NOUT];
  out_state_t  st_ff       [NOUT];
  out_state_t  nxt_st      [NOUT];
  logic [NOUT-1:0] en_ff;
  logic [NOUT-1:0] nxt_en;
  logic [NOUT-1:0] rst_stb_ff;
  logic [NOUT-1:0] nxt_rst_stb;
  logic [NOUT-1:0] tmr_start;
  logic [NOUT-1:0] tmr_cancel;
  logic [NOUT-1:0] tmr_busy;
  logic [NOUT-1:0] tmr_done;
  logic            alert_n_ff;
  logic            nxt_alert_n;
  logic [7:0]      rd_ff;
  logic [7:0]      nxt_rd;

  // bits 2:0 never reach this decision
  function automatic logic restarts(input logic [7:0] cfg);
    restarts = cfg[fault_resp_pkg::MODE_MSB:fault_resp_pkg::MODE_LSB]
                 == fault_resp_pkg::MODE_DISABLE
            && cfg[fault_resp_pkg::RETRY_MSB:fault_resp_pkg::RETRY_LSB]
                 == fault_resp_pkg::RETRY_FOREVER;
  endfunction

  // register file, one byte per command code per page
  always_comb begin
    for (int i = 0; i < NOUT; i++) begin
      nxt_oc_cfg[i] = oc_cfg_ff[i];
      nxt_uc_cfg[i] = uc_cfg_ff[i];
      if (WR_STB && !WRITE_PROTECT && int'(PAGE) == i) begin
        if (CMD_CODE == fault_resp_pkg::OC_RESP_CMD) begin
          nxt_oc_cfg[i] = WR_DATA;
        end
        if (CMD_CODE == fault_resp_pkg::UC_RESP_CMD) begin
          nxt_uc_cfg[i] = WR_DATA;
        end
      end
    end
    nxt_rd = 8'h00;
    for (int i = 0; i < NOUT; i++) begin
      if (int'(PAGE) == i) begin
        if (CMD_CODE == fault_resp_pkg::OC_RESP_CMD) begin
          nxt_rd = oc_cfg_ff[i];
        end else if (CMD_CODE == fault_resp_pkg::UC_RESP_CMD) begin
          nxt_rd = uc_cfg_ff[i];
        end
      end
    end
  end

  always_ff @(posedge MCLK) begin
    for (int i = 0; i < NOUT; i++) begin
      if (!RST_N) begin
        oc_cfg_ff[i] <= fault_resp_pkg::RESP_RESET;
        uc_cfg_ff[i] <= fault_resp_pkg::RESP_RESET;
      end else begin
        oc_cfg_ff[i] <= nxt_oc_cfg[i];
        uc_cfg_ff[i] <= nxt_uc_cfg[i];
      end
    end
    if (!RST_N) begin
      rd_ff <= 8'h00;
    end else begin
      rd_ff <= nxt_rd;
    end
  end

  // fault status, alert and per-output shutdown/retry sequencing
  always_comb begin
    logic any;
    logic oc_rs;
    logic uc_rs;
    logic hold;
    any = 1'b0;
    oc_rs = 1'b0;
    uc_rs = 1'b0;
    hold = 1'b0;
    for (int i = 0; i < NOUT; i++) begin
      nxt_stat[i]    = stat_ff[i];
      nxt_st[i]      = st_ff[i];
      nxt_rst_stb[i] = 1'b0;
      tmr_start[i]   = 1'b0;
      tmr_cancel[i]  = 1'b0;
      oc_rs = restarts(oc_cfg_ff[i]);
      uc_rs = restarts(uc_cfg_ff[i]);
      // set wins over a clear arriving in the same cycle
      if (CLEAR_FAULTS) begin
        nxt_stat[i] = 2'b00;
      end
      if (OC_FAULT[i]) begin
        nxt_stat[i][fault_resp_pkg::STATUS_OC_BIT] = 1'b1;
      end
      if (UC_FAULT[i]) begin
        nxt_stat[i][fault_resp_pkg::STATUS_UC_BIT] = 1'b1;
      end
      if (|nxt_stat[i]) begin
        any = 1'b1;
      end
      // unused mode codes fall back to the held-off response
      hold = (OC_FAULT[i] && !oc_rs) || (UC_FAULT[i] && !uc_rs);
      if (!CMD_ON[i] || OTHER_FAULT[i]) begin
        tmr_cancel[i] = 1'b1;
        nxt_st[i] = ST_OFF;
      end else if (hold) begin
        tmr_cancel[i] = 1'b1;
        nxt_st[i] = ST_OFF;
      end else begin
        unique case (st_ff[i])
          ST_RUN: begin
            if (OC_FAULT[i] || UC_FAULT[i]) begin
              tmr_start[i] = 1'b1;
              nxt_st[i] = ST_WAIT;
            end
          end
          ST_OFF: begin
            if (CLEAR_FAULTS) begin
              nxt_st[i] = ST_RUN;
              nxt_rst_stb[i] = 1'b1;
            end
          end
          ST_WAIT: begin
            // a fault still standing neither delays nor blocks the attempt;
            // if it is there once running, the cycle simply repeats
            if (tmr_done[i]) begin
              nxt_st[i] = ST_RUN;
              nxt_rst_stb[i] = 1'b1;
            end
          end
        endcase
      end
      nxt_en[i] = (nxt_st[i] == ST_RUN) && CMD_ON[i];
    end
    nxt_alert_n = !any;
  end

  always_ff @(posedge MCLK) begin
    for (int i = 0; i < NOUT; i++) begin
      if (!RST_N) begin
        stat_ff[i] <= 2'b00;
        st_ff[i]   <= ST_RUN;
      end else begin
        stat_ff[i] <= nxt_stat[i];
        st_ff[i]   <= nxt_st[i];
      end
    end
    if (!RST_N) begin
      en_ff      <= '0;
      rst_stb_ff <= '0;
      alert_n_ff <= 1'b1;
    end else begin
      en_ff      <= nxt_en;
      rst_stb_ff <= nxt_rst_stb;
      alert_n_ff <= nxt_alert_n;
    end
  end

  for (genvar g = 0; g < NOUT; g++) begin : g_tmr
    retry_timer #(.CYCLES(RETRY_CYCLES)) u_tmr (
      .clk    (MCLK),
      .rst_n  (RST_N),
      .start  (tmr_start[g]),
      .cancel (tmr_cancel[g]),
      .busy   (tmr_busy[g]),
      .done   (tmr_done[g])
    );
  end

  assign RD_DATA       = rd_ff;
  assign OUTPUT_ENABLE = en_ff;
  assign RESTART_STB   = rst_stb_ff;
  assign ALERT_LINE_N  = alert_n_ff;
  always_comb begin
    for (int i = 0; i < NOUT; i++) begin
      OUTPUT_CURRENT_STATUS[i] = stat_ff[i];
    end
  end

  // assertions
  property p_reset_cfg;
    @(posedge MCLK) $rose(RST_N) |-> oc_cfg_ff[0] == 8'h80
      && uc_cfg_ff[1] == 8'h80;
  endproperty
  a_reset_cfg: assert property (p_reset_cfg)
    else $error("response register not 80h after reset");

  property p_alert;
    @(posedge MCLK) disable iff (!RST_N)
      (OC_FAULT[0] || UC_FAULT[1]) |=> !ALERT_LINE_N;
  endproperty
  a_alert: assert property (p_alert)
    else $error("alert not asserted on fault");

  property p_sticky;
    @(posedge MCLK) disable iff (!RST_N)
      (stat_ff[0][1] && !CLEAR_FAULTS) |=> stat_ff[0][1];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("status bit cleared without clear faults");

  property p_oc_status;
    @(posedge MCLK) disable iff (!RST_N)
      OC_FAULT[0] |=> OUTPUT_CURRENT_STATUS[0][1];
  endproperty
  a_oc_status: assert property (p_oc_status)
    else $error("overcurrent status not set");

  property p_uc_status;
    @(posedge MCLK) disable iff (!RST_N)
      UC_FAULT[1] |=> OUTPUT_CURRENT_STATUS[1][0];
  endproperty
  a_uc_status: assert property (p_uc_status)
    else $error("undercurrent status not set");

  property p_disable;
    @(posedge MCLK) disable iff (!RST_N)
      (OC_FAULT[0] || UC_FAULT[0]) && !tmr_done[0] |=> !OUTPUT_ENABLE[0];
  endproperty
  a_disable: assert property (p_disable)
    else $error("output not disabled at once on fault");

  property p_hold_off;
    @(posedge MCLK) disable iff (!RST_N)
      (st_ff[0] == ST_OFF && !CLEAR_FAULTS) |=> !OUTPUT_ENABLE[0];
  endproperty
  a_hold_off: assert property (p_hold_off)
    else $error("output re-enabled before clear faults");

  property p_stop;
    @(posedge MCLK) disable iff (!RST_N)
      (!CMD_ON[NOUT-1] || OTHER_FAULT[NOUT-1]) |=> st_ff[NOUT-1] != ST_WAIT;
  endproperty
  a_stop: assert property (p_stop)
    else $error("retry continued after off or other fault");

  property p_wp;
    @(posedge MCLK) disable iff (!RST_N)
      (WR_STB && WRITE_PROTECT) |=> $stable(oc_cfg_ff[0])
        && $stable(uc_cfg_ff[0]);
  endproperty
  a_wp: assert property (p_wp)
    else $error("write accepted under protection");

  property p_retry_gap;
    @(posedge MCLK) disable iff (!RST_N)
      (st_ff[NOUT-1] == ST_WAIT && $past(st_ff[NOUT-1]) != ST_WAIT)
        |-> (!RESTART_STB[NOUT-1]) [*2];
  endproperty
  a_retry_gap: assert property (p_retry_gap)
    else $error("restart came too soon after fault");

  // cycles spent waiting on the last output, for the spacing check
  logic [31:0] wait_cnt_ff;
  logic [31:0] nxt_wait_cnt;

  always_comb begin
    nxt_wait_cnt = 32'h0;
    if (st_ff[NOUT-1] == ST_WAIT) begin
      nxt_wait_cnt = wait_cnt_ff + 32'h1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      wait_cnt_ff <= 32'h0;
    end else begin
      wait_cnt_ff <= nxt_wait_cnt;
    end
  end

  property p_retry_len;
    @(posedge MCLK) disable iff (!RST_N)
      (RESTART_STB[NOUT-1] && wait_cnt_ff != 32'h0)
        |-> wait_cnt_ff == 32'(RETRY_CYCLES);
  endproperty
  a_retry_len: assert property (p_retry_len)
    else $error("restart not one retry interval after shutdown");

  property p_wait_busy;
    @(posedge MCLK) disable iff (!RST_N)
      st_ff[NOUT-1] == ST_WAIT |-> tmr_busy[NOUT-1];
  endproperty
  a_wait_busy: assert property (p_wait_busy)
    else $error("waiting for a restart with no interval running");
endmodule

//--- design/fault_resp_pkg.sv
package fault_resp_pkg;

  localparam int          NUM_OUTPUTS     = 2;
  localparam logic [7:0]  OC_RESP_CMD     = 8'he5;
  localparam logic [7:0]  UC_RESP_CMD     = 8'he6;
  localparam logic [7:0]  RESP_RESET      = 8'h80;
  localparam int          MODE_MSB        = 7;
  localparam int          MODE_LSB        = 6;
  localparam int          RETRY_MSB       = 5;
  localparam int          RETRY_LSB       = 3;
  localparam logic [1:0]  MODE_DISABLE    = 2'h2;
  localparam logic [2:0]  RETRY_NONE      = 3'h0;
  localparam logic [2:0]  RETRY_FOREVER   = 3'h7;
  localparam int          STATUS_OC_BIT   = 1;
  localparam int          STATUS_UC_BIT   = 0;
  localparam int          CLK_HZ          = 20000000;
  localparam int          RETRY_MS        = 70;
  localparam longint      RETRY_CYCLES_L  =
    (longint'(RETRY_MS) * longint'(CLK_HZ)) / 1000;
  localparam int          RETRY_CYCLES    = int'(RETRY_CYCLES_L);

endpackage

//--- design/retry_timer.sv
`timescale 1ns/1ps
// one-shot retry interval counter for one output
module retry_timer #(
  parameter int CYCLES = fault_resp_pkg::RETRY_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  input  wire logic cancel,
  output logic      busy,
  output logic      done
);
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic        busy_ff;
  logic        nxt_busy;

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_busy = busy_ff;
    if (cancel) begin
      nxt_busy = 1'b0;
    end else if (start) begin
      nxt_busy = 1'b1;
      nxt_cnt  = 32'(CYCLES - 1);
    end else if (busy_ff) begin
      if (cnt_ff == 32'h0) begin
        nxt_busy = 1'b0;
      end else begin
        nxt_cnt = cnt_ff - 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff  <= 32'h0;
      busy_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      busy_ff <= nxt_busy;
    end
  end

  assign busy = busy_ff;
  // done shows in the last counted cycle, so the user's reaction lands
  // exactly CYCLES edges after start rather than one edge late
  assign done = busy_ff && (cnt_ff == 32'h0);
endmodule

//--- verification/host_model.sv
`timescale 1ns/1ps
// management bus host: one access per call, all changes at the falling edge
module host_model (
  input  wire logic       clk,
  output logic [7:0]      cmd_code,
  output logic [0:0]      page,
  output logic            wr_stb,
  output logic [7:0]      wr_data,
  output logic            clear_faults
);
  initial begin
    cmd_code = 8'h00;
    page = 1'b0;
    wr_stb = 1'b0;
    wr_data = 8'h00;
    clear_faults = 1'b0;
  end

  task automatic wr(input logic [7:0] c, input logic [0:0] p,
                    input logic [7:0] d);
    @(negedge clk);
    cmd_code = c;
    page = p;
    wr_data = d;
    wr_stb = 1'b1;
    @(negedge clk);
    wr_stb = 1'b0;
    // stale byte never lingers on the data lines
    wr_data = ~d;
  endtask

  // read data is registered, so it is settled one edge later
  task automatic rd(input logic [7:0] c, input logic [0:0] p);
    @(negedge clk);
    cmd_code = c;
    page = p;
    @(negedge clk);
  endtask

  task automatic clr();
    @(negedge clk);
    clear_faults = 1'b1;
    @(negedge clk);
    clear_faults = 1'b0;
  endtask
endmodule

//--- verification/test_output_current_fault_response.sv
`timescale 1ns/1ps
module test_output_current_fault_response;
  localparam int RC = 20;
  typedef struct packed {
    logic [7:0] c;
    logic       p;
    logic [7:0] d;
    logic [7:0] e;
  } row_t;
  logic       mclk, rst_n, wp, clr, wr_stb, alert_n;
  logic [7:0] cmd, wdata, rdata;
  logic [0:0] page;
  logic [1:0] oc, uc, on, oth, oe, rs;
  logic [1:0] st [2];
  int         err_count, comparisons, n;
  row_t       rows [3];

  host_model host (.clk(mclk), .cmd_code(cmd), .page(page), .wr_stb(wr_stb),
    .wr_data(wdata), .clear_faults(clr));

  output_current_fault_response #(.RETRY_CYCLES(RC)) dut (.MCLK(mclk),
    .RST_N(rst_n), .CMD_CODE(cmd), .PAGE(page), .WR_STB(wr_stb),
    .WR_DATA(wdata), .WRITE_PROTECT(wp), .CLEAR_FAULTS(clr), .OC_FAULT(oc),
    .UC_FAULT(uc), .CMD_ON(on), .OTHER_FAULT(oth), .RD_DATA(rdata),
    .OUTPUT_ENABLE(oe), .RESTART_STB(rs), .OUTPUT_CURRENT_STATUS(st),
    .ALERT_LINE_N(alert_n));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wait_oe(input int i, input int lim, output int cnt);
    cnt = 0;
    while (oe[i] !== 1'b1 && cnt < lim) begin
      @(negedge mclk);
      cnt++;
    end
    if (cnt >= lim) begin
      err_count++;
      $display("mismatch at %0t: output %0d never restarted", $time, i);
      end_sim();
    end
  endtask

  // one-cycle fault pulse; returns where the reaction is settled
  task automatic pulse(input logic [1:0] o, input logic [1:0] u);
    @(negedge mclk);
    oc = o;
    uc = u;
    @(negedge mclk);
    oc = 2'b00;
    uc = 2'b00;
  endtask

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    rst_n = 1'b0;
    wp = 1'b0;
    oc = 2'b00;
    uc = 2'b00;
    on = 2'b11;
    oth = 2'b00;
    err_count = 0;
    comparisons = 0;
    // mode 10 retry 000 with ignored low bits; retry forever; unmapped code
    rows[0] = '{8'he5, 1'b0, 8'h87, 8'h87};
    rows[1] = '{8'he6, 1'b1, 8'hb8, 8'hb8};
    rows[2] = '{8'hd0, 1'b0, 8'h55, 8'h00};
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    chk(alert_n, 1'b1, "alert after reset");
    for (int i = 0; i < 4; i++) begin
      host.rd(i[0] ? 8'he6 : 8'he5, i[1]);
      chk(rdata, 8'h80, "reset value");
    end
    foreach (rows[i]) begin
      host.wr(rows[i].c, rows[i].p, rows[i].d);
      host.rd(rows[i].c, rows[i].p);
      chk(rdata, rows[i].e, "readback");
    end
    host.rd(8'he5, 1'b1);
    chk(rdata, 8'h80, "other page untouched");
    wp = 1'b1;
    host.wr(8'he5, 1'b0, 8'h00);
    wp = 1'b0;
    host.rd(8'he5, 1'b0);
    chk(rdata, 8'h87, "protected write");

    pulse(2'b01, 2'b00);
    chk(st[0], 2'b10, "oc status");
    chk(alert_n, 1'b0, "alert on oc");
    chk(oe, 2'b10, "oc disables output 0 only");
    repeat (RC + 5) @(negedge mclk);
    chk(oe[0], 1'b0, "held off");
    chk(st[0], 2'b10, "status sticky");
    host.clr();
    wait_oe(0, 4, n);
    chk(st[0], 2'b00, "status cleared");
    chk(alert_n, 1'b1, "alert released");
    // fault and clear in the same cycle: the fault must survive
    fork
      host.clr();
      pulse(2'b01, 2'b00);
    join
    chk(st[0], 2'b10, "set wins over clear");
    chk(oe[0], 1'b0, "held off again");
    host.clr();

    // retry forever: each fault gives one restart one interval later
    for (int k = 0; k < 2; k++) begin
      pulse(2'b00, 2'b10);
      chk(st[1], 2'b01, "uc status");
      chk(alert_n, 1'b0, "alert on uc");
      chk(oe[1], 1'b0, "uc disables output");
      wait_oe(1, RC + 10, n);
      chk(8'(n), 8'(RC), "retry spacing");
      chk(rs[1], 1'b1, "restart strobe");
      chk(st[1], 2'b01, "status kept after restart");
    end
    // fault left standing: the restart still comes one interval after it
    @(negedge mclk);
    uc = 2'b10;
    @(negedge mclk);
    wait_oe(1, RC + 10, n);
    uc = 2'b00;
    chk(8'(n), 8'(RC), "blind restart");
    // command back on at once, so only the stop keeps the output down
    pulse(2'b00, 2'b10);
    on[1] = 1'b0;
    repeat (2) @(negedge mclk);
    on[1] = 1'b1;
    repeat (RC + 6) @(negedge mclk);
    chk(oe[1], 1'b0, "commanded off stops retry");
    host.clr();
    pulse(2'b00, 2'b10);
    oth[1] = 1'b1;
    repeat (RC + 6) @(negedge mclk);
    chk(oe[1], 1'b0, "other fault stops retry");
    end_sim();
  end
endmodule
